// ===== olc_pkg.sv
// Purpose: Shared constants and types of the octal output control logic.
// Assumes: One 100 MHz clock; AXI4-Lite register access with 32-bit data.
// Notes: Each register takes one aligned word; offsets are byte addresses.
package olc_pkg;
   // ==========================================================================
   // Clock and timing
   // ==========================================================================
   localparam int unsigned CLK_FREQ_HZ = 100_000_000;
   localparam int unsigned FAULT_HOLD_TIME_MS = 200;
   localparam int unsigned FAULT_HOLD_CYCLES = FAULT_HOLD_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int unsigned OPEN_LOAD_DEBOUNCE_TIME_US = 50;
   localparam int unsigned OPEN_LOAD_DEBOUNCE_CYCLES =
      OPEN_LOAD_DEBOUNCE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int unsigned GLITCH_FILTER_TIME_NS = 100;
   localparam int unsigned GLITCH_FILTER_CYCLES =
      (GLITCH_FILTER_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam logic [7:0] OUTPUT_STATE_ADDR = 8'h00;
   localparam logic [7:0] CHANNEL_CONFIG_ADDR = 8'h04;
   localparam logic [7:0] PAIR_JOIN_ADDR = 8'h0c;
   localparam logic [7:0] FAULT_FLAGS_ADDR = 8'h10;
   localparam logic [7:0] LIVE_STATUS_ADDR = 8'h14;
   localparam int unsigned LOWER_JOIN_BIT = 0;
   localparam int unsigned UPPER_JOIN_BIT = 1;
   localparam int unsigned STATUS_SERIAL_BIT = 8;
   localparam int unsigned STATUS_WORD16_BIT = 9;
   localparam int unsigned STATUS_FAULT_BIT = 10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Per-channel drive bundle sent to the output stage.
   typedef struct packed {
      logic [7:0] high_side_switch;
      logic [7:0] low_side;
      logic [7:0] pull_up;
      logic [7:0] fault_led;
   } olc_drive_t;
endpackage : olc_pkg

// ===== olc_stable.sv
// Purpose: Passes a vector on only after it has held still for a set time.
// Assumes: Input is synchronous to aclk.
// Notes: Serves both as glitch filter and as open-load debouncer.
`timescale 1ns/1ps
module olc_stable #(
   parameter int unsigned W = 1,
   parameter int unsigned CYCLES = 4,
   parameter logic [W-1:0] RESET_VALUE = '0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [W-1:0] sample;
   logic [CW-1:0] count;

   // ==========================================================================
   // Stability counter
   // ==========================================================================
   // Any change restarts the count, so a glitch shorter than the window never reaches q.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample <= RESET_VALUE;
         count <= '0;
         q <= RESET_VALUE;
      end else begin
         sample <= d;
         if (d != sample) begin
            count <= '0;
         end else if (count != LAST) begin
            count <= count + CW'(1);
         end else begin
            q <= sample;
         end
      end
   end
endmodule : olc_stable

// ===== olc_top.sv
// Purpose: Pin, mode, pairing and open-load control of an eight-channel driver.
// Assumes: Inputs synchronous to aclk; registers reached over AXI4-Lite.
// Notes: Analog comparator results arrive as plain inputs per channel.
// Contract
// - Serial-select high: outputs from registers; low: dual pins drive channels directly.
// - Serial mode with open-load pin high enables detection on all high-side channels.
// - Serial mode: configure pin high routes writes to configuration, low to outputs.
// - Parallel mode: configure and word-length pins drive channels seven and eight.
// - Serial mode: word-length pin high selects 16-bit frames, low 8-bit.
// - Filter-enable high glitch-filters all parallel inputs and chip select.
// - Fault output pulled low on driver shutdown or open-load detection.
// - Push-pull pin high: all unjoined channels push-pull; low: high-side unless a serial-mode config bit sets push-pull.
// - Output-enable low turns off switches, push-pull drivers and LEDs.
// - Register three holds a lower and an upper pair join bit.
// - Lower join: channels 1-2 follow input 1, channels 3-4 input 3.
// - Upper join: channels 5-6 follow input 5, channels 7-8 input 7.
// - Joined pairs never run push-pull, only high-side.
// - Fault diagnostics stay per channel even when paired.
// - Open-load enabled per channel by config bit or globally by pin.
// - Open-load detection only in high-side mode, switch on or off.
// - Switch off: pull-up on, open load when voltage above threshold.
// - Switch on: open load when switch drop shows current below threshold.
// - Open load reported only after input and load stable for debounce time.
// - Open load sets the channel fault flag in diagnostic data.
// - Open load lights channel fault LED at least 200 ms.
// - Open load holds the global fault output at least 200 ms.
`timescale 1ns/1ps
module olc_top
   import olc_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = FAULT_HOLD_CYCLES,
   parameter int unsigned DEBOUNCE_CYCLES = OPEN_LOAD_DEBOUNCE_CYCLES,
   parameter int unsigned FILTER_CYCLES = GLITCH_FILTER_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_select,
   input wire logic open_load_enable_or_input1,
   input wire logic [4:0] input2_to_6,
   input wire logic configure_or_input7,
   input wire logic word_length_or_input8,
   input wire logic filter_enable,
   input wire logic push_pull_select,
   input wire logic output_enable,
   input wire logic chip_select_n,
   input wire logic [7:0] driver_shutdown,
   input wire logic [7:0] off_level_above,
   input wire logic [7:0] on_current_below,
   output olc_pkg::olc_drive_t drive,
   output logic fault_n_oe,
   output logic word16_select,
   output logic config_route,
   output logic chip_select_n_filtered
);
   import olc_pkg::*;
   localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
   localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYCLES);

   logic [7:0] output_state;
   logic [7:0] cfg_open_load;
   logic [7:0] cfg_push_pull;
   logic lower_pair_join;
   logic upper_pair_join;
   logic [7:0] fault_flags;
   logic [8:0] filtered;
   logic [8:0] pins_used;
   logic [7:0] level;
   logic [7:0] join_mask;
   logic [7:0] pp_mode;
   logic [7:0] ol_enable;
   logic [7:0] ol_raw;
   logic [7:0] ol_detected;
   logic [HW-1:0] led_count [8];
   logic [HW-1:0] global_count;
   logic [7:0] led_hold;
   logic aw_full;
   logic w_full;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic next_aw_full;
   logic next_w_full;
   logic do_write;
   logic wr_outputs;
   logic wr_config;
   logic [31:0] merged_outputs;
   logic [31:0] merged_config;

   // Merge a write under byte strobes into an old register value.
   function automatic logic [31:0] olc_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = data[8*b +: 8];
         end
      end
      return r;
   endfunction : olc_merge

   // ==========================================================================
   // Input filtering and pin selection
   // ==========================================================================
   // Parallel pins and chip select pass through one shared stability filter.
   olc_stable #(.W(9), .CYCLES(FILTER_CYCLES), .RESET_VALUE(9'h100)) u_filter (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({chip_select_n, word_length_or_input8, configure_or_input7, input2_to_6,
          open_load_enable_or_input1}),
      .q(filtered)
   );

   // Filter bypass keeps the fast path available when filtering is off.
   assign pins_used = filter_enable ? filtered :
                      {chip_select_n, word_length_or_input8, configure_or_input7, input2_to_6,
                       open_load_enable_or_input1};

   // Channel levels come from the register in serial mode, from the pins otherwise.
   always_comb begin
      level = serial_select ? output_state : pins_used[7:0];
      if (lower_pair_join) begin
         level[1] = level[0];
         level[3] = level[2];
      end
      if (upper_pair_join) begin
         level[5] = level[4];
         level[7] = level[6];
      end
   end

   // Mode selection: joined pairs are forced high-side.
   assign join_mask = {{4{upper_pair_join}}, {4{lower_pair_join}}};
   assign pp_mode = ({8{push_pull_select}} | (serial_select ? cfg_push_pull : 8'h00))
                    & ~join_mask;

   // Open-load enable only in high-side mode, per channel or globally by pin.
   assign ol_enable = ((serial_select && pins_used[0]) ? 8'hff : cfg_open_load)
                      & ~pp_mode;

   // Comparator choice follows the switch state of each channel.
   assign ol_raw = ol_enable & ((level & on_current_below) |
                                (~level & off_level_above));

   // ==========================================================================
   // Open-load debounce and hold timers
   // ==========================================================================
   for (genvar i = 0; i < 8; i++) begin : g_chan
      logic [1:0] settled;
      // Input state and load condition must both hold still before a report.
      olc_stable #(.W(2), .CYCLES(DEBOUNCE_CYCLES), .RESET_VALUE(2'h0)) u_deb (
         .aclk(aclk),
         .aresetn(aresetn),
         .d({level[i], ol_raw[i]}),
         .q(settled)
      );
      assign ol_detected[i] = settled[0] & ol_raw[i];

      // Each channel restarts its own LED hold whenever a detection is seen.
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            led_count[i] <= '0;
         end else if (ol_detected[i]) begin
            led_count[i] <= HOLD_LOAD;
         end else if (led_count[i] != '0) begin
            led_count[i] <= led_count[i] - HW'(1);
         end
      end
      assign led_hold[i] = (led_count[i] != '0) | ol_detected[i] | driver_shutdown[i];
   end

   // Global fault hold, restarted by any open-load detection.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         global_count <= '0;
      end else if (|ol_detected) begin
         global_count <= HOLD_LOAD;
      end else if (global_count != '0) begin
         global_count <= global_count - HW'(1);
      end
   end

   // ==========================================================================
   // Registered outputs
   // ==========================================================================
   // Every output leaves through a flip-flop so the pins never see decode hazards.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive <= '0;
         fault_n_oe <= 1'b0;
         word16_select <= 1'b0;
         config_route <= 1'b0;
         chip_select_n_filtered <= 1'b1;
      end else begin
         drive.high_side_switch <= output_enable ? level : 8'h00;
         drive.low_side <= output_enable ? (pp_mode & ~level) : 8'h00;
         drive.pull_up <= output_enable ? (ol_enable & ~level) : 8'h00;
         drive.fault_led <= output_enable ? led_hold : 8'h00;
         fault_n_oe <= (|driver_shutdown) | (|ol_detected) | (global_count != '0);
         word16_select <= serial_select & pins_used[7];
         config_route <= serial_select & pins_used[6];
         chip_select_n_filtered <= pins_used[8];
      end
   end

   // ==========================================================================
   // AXI4-Lite write path
   // ==========================================================================
   assign next_aw_full = (aw_full | (s_axi_awvalid & s_axi_awready)) &
                         ~(s_axi_bvalid & s_axi_bready);
   assign next_w_full = (w_full | (s_axi_wvalid & s_axi_wready)) &
                        ~(s_axi_bvalid & s_axi_bready);
   assign do_write = aw_full & w_full & ~s_axi_bvalid;
   assign wr_outputs = serial_select & ~pins_used[6];
   assign wr_config = serial_select & pins_used[6];
   // Strobe merges of the writable words; a function result cannot be sliced in place.
   assign merged_outputs = olc_merge({24'h0, output_state}, w_data, w_strb);
   assign merged_config = olc_merge({16'h0, cfg_push_pull, cfg_open_load}, w_data, w_strb);

   // Address and data are caught independently and held until the response is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         s_axi_awready <= ~next_aw_full;
         s_axi_wready <= ~next_w_full;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         unique case (aw_addr)
            OUTPUT_STATE_ADDR, CHANNEL_CONFIG_ADDR, PAIR_JOIN_ADDR, FAULT_FLAGS_ADDR,
            LIVE_STATUS_ADDR: s_axi_bresp <= RESP_OKAY;
            default: s_axi_bresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Output states accept writes only when routed to them.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_state <= 8'h00;
      end else if (do_write && wr_outputs && aw_addr == OUTPUT_STATE_ADDR) begin
         output_state <= merged_outputs[7:0];
      end
   end

   // Configuration, including the pair join bits, accepts writes only when routed to it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_open_load <= 8'h00;
         cfg_push_pull <= 8'h00;
         lower_pair_join <= 1'b0;
         upper_pair_join <= 1'b0;
      end else if (do_write && wr_config) begin
         if (aw_addr == CHANNEL_CONFIG_ADDR) begin
            {cfg_push_pull, cfg_open_load} <= merged_config[15:0];
         end
         if (aw_addr == PAIR_JOIN_ADDR && w_strb[0]) begin
            lower_pair_join <= w_data[LOWER_JOIN_BIT];
            upper_pair_join <= w_data[UPPER_JOIN_BIT];
         end
      end
   end

   // Fault flags: shutdown or open load sets, writing one clears; a set wins the clash.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_flags <= 8'h00;
      end else begin
         if (do_write && aw_addr == FAULT_FLAGS_ADDR && w_strb[0]) begin
            fault_flags <= (fault_flags & ~w_data[7:0]) | ol_detected | driver_shutdown;
         end else begin
            fault_flags <= fault_flags | ol_detected | driver_shutdown;
         end
      end
   end

   // ==========================================================================
   // AXI4-Lite read path
   // ==========================================================================
   // One read at a time; the data word is captured when the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         unique case (s_axi_araddr)
            OUTPUT_STATE_ADDR: s_axi_rdata <= {24'h0, output_state};
            CHANNEL_CONFIG_ADDR: s_axi_rdata <= {16'h0, cfg_push_pull, cfg_open_load};
            PAIR_JOIN_ADDR: s_axi_rdata <= {30'h0, upper_pair_join, lower_pair_join};
            FAULT_FLAGS_ADDR: s_axi_rdata <= {24'h0, fault_flags};
            LIVE_STATUS_ADDR: s_axi_rdata <= {21'h0, fault_n_oe, word16_select,
                                              serial_select, ol_detected};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ol_seen;
      |ol_detected;
   endsequence
   sequence s_fault_held;
      fault_n_oe [*8];
   endsequence

   property p_enable_off;
      !output_enable |=> drive.high_side_switch == 8'h00 && drive.low_side == 8'h00 &&
                         drive.fault_led == 8'h00;
   endproperty
   a_enable_off: assert property (p_enable_off) else $error("drive on while disabled");

   property p_lower_join;
      lower_pair_join && output_enable |=>
         drive.high_side_switch[1] == drive.high_side_switch[0] &&
         drive.high_side_switch[3] == drive.high_side_switch[2] && drive.low_side[3:0] == 4'h0;
   endproperty
   a_lower_join: assert property (p_lower_join) else $error("lower pair not joined");

   property p_upper_join;
      upper_pair_join && output_enable |=>
         drive.high_side_switch[5] == drive.high_side_switch[4] &&
         drive.high_side_switch[7] == drive.high_side_switch[6] && drive.low_side[7:4] == 4'h0;
   endproperty
   a_upper_join: assert property (p_upper_join) else $error("upper pair not joined");

   property p_fault_hold;
      s_ol_seen |=> s_fault_held;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault output not held");

   property p_shutdown_fault;
      |driver_shutdown |=> fault_n_oe;
   endproperty
   a_shutdown_fault: assert property (p_shutdown_fault) else $error("no shutdown fault");

   property p_led_hold;
      ol_detected[0] && output_enable ##1 output_enable [*3] |-> drive.fault_led[0];
   endproperty
   a_led_hold: assert property (p_led_hold) else $error("fault LED not held");

   property p_flag_set;
      s_ol_seen |=> (fault_flags & $past(ol_detected)) == $past(ol_detected);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("fault flag missed");

   property p_word16;
      serial_select && !filter_enable |=> word16_select == $past(word_length_or_input8);
   endproperty
   a_word16: assert property (p_word16) else $error("frame length mismatch");

   property p_pullup_high_side;
      drive.pull_up != 8'h00 |-> (drive.pull_up & drive.low_side) == 8'h00 &&
                                 (drive.pull_up & drive.high_side_switch) == 8'h00;
   endproperty
   a_pullup_high_side: assert property (p_pullup_high_side) else $error("bad pull-up");
endmodule : olc_top

// ===== olc_load_model.sv
// Purpose: Behavioural load bank on the eight driver outputs.
// Assumes: Open wires are commanded by the bench.
// Notes: A wired load keeps an off output low and draws full current when on.
`timescale 1ns/1ps
module olc_load_model
   import olc_pkg::*;
(
   input wire olc_pkg::olc_drive_t drive,
   input wire logic [7:0] open_wire,
   output logic [7:0] off_level_above,
   output logic [7:0] on_current_below
);
   // Only a broken wire lets the pull-up win or the current collapse.
   always_comb begin
      off_level_above = open_wire & drive.pull_up;
      on_current_below = open_wire & drive.high_side_switch;
   end
endmodule : olc_load_model

// ===== tb_olc_top.sv
// Purpose: Self-checking bench of the octal output control logic.
// Assumes: Shortened hold, debounce and filter counts.
// Notes: Waits of a few edges cover the registered pin-to-drive path.
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_olc_top;
   import olc_pkg::*;
   // ====================
   // Signals and design
   // ====================
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
   logic awready, wready, bvalid, arready, rvalid, fault_n_oe, w16, croute, csf;
   logic ser = 0, flt = 0, pp = 0, oe = 1, csn = 1, bready = 1, rready = 1;
   logic [3:0] wstrb = 4'hf;
   logic [7:0] awaddr = 0, araddr = 0, in8 = 0, sd = 0, ow = 0, v, olv, ocb;
   logic [31:0] wdata = 0, rdata, rd_v, seed = 32'h4fd4b315;
   logic [1:0] bresp, rresp, resp;
   olc_drive_t d;
   int err_total = 0, samples_checked = 0;
   // Free-running 100 MHz clock.
   always #5 aclk = ~aclk;
   olc_top #(.HOLD_CYCLES(20), .DEBOUNCE_CYCLES(4), .FILTER_CYCLES(2)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .serial_select(ser), .open_load_enable_or_input1(in8[0]), .input2_to_6(in8[5:1]),
      .configure_or_input7(in8[6]), .word_length_or_input8(in8[7]),
      .filter_enable(flt), .push_pull_select(pp), .output_enable(oe),
      .chip_select_n(csn), .driver_shutdown(sd), .off_level_above(olv),
      .on_current_below(ocb), .drive(d), .fault_n_oe(fault_n_oe), .word16_select(w16),
      .config_route(croute), .chip_select_n_filtered(csf));
   olc_load_model u_load (.drive(d), .open_wire(ow), .off_level_above(olv),
      .on_current_below(ocb));
   // ====================
   // Helpers
   // ====================
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Joined pairs copy the odd channel's input onto the even one.
   function automatic logic [7:0] jmap(logic [7:0] x, logic [1:0] j);
      jmap = x;
      if (j[0]) begin
         jmap[1] = x[0];
         jmap[3] = x[2];
      end
      if (j[1]) begin
         jmap[5] = x[4];
         jmap[7] = x[6];
      end
   endfunction : jmap
   task automatic end_of_test();
      $display("Checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task automatic tick(int n);
      repeat (n) @(posedge aclk);
   endtask : tick
   // Ready is sampled at the edge, so each channel drops only once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= x;
      awvalid <= 1;
      wvalid <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid && n < 50);
      resp = bresp;
      if (n >= 50) begin
         err_total++;
         end_of_test();
      end
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 0;
      end while (!rvalid && n < 50);
      rd_v = rdata;
      resp = rresp;
      if (n >= 50) begin
         err_total++;
         end_of_test();
      end
   endtask : rd
   // ====================
   // Main sequence
   // ====================
   initial begin
      tick(8);
      `CHK("drive_rst", 32'h0, d)
      aresetn <= 1;
      tick(3);
      wr(8'h20, 0);
      `CHK("bresp_bad", RESP_SLVERR, resp)
      rd(8'h20);
      `CHK("rresp_bad", RESP_SLVERR, resp)
      for (int i = 0; i < 8; i++) begin
         v = rnd();
         in8 <= v;
         pp <= i[0];
         tick(3);
         `CHK("hs_par", v, d.high_side_switch)
         `CHK("ls_par", (i[0] ? ~v : 8'h0), d.low_side)
         `CHK("w16_par", 1'b0, w16)
      end
      oe <= 0;
      tick(3);
      `CHK("drive_off", 32'h0, d)
      oe <= 1;
      ser <= 1;
      pp <= 0;
      in8 <= 8'h40;
      tick(3);
      `CHK("route_cfg", 1'b1, croute)
      wr(PAIR_JOIN_ADDR, 3);
      wr(OUTPUT_STATE_ADDR, 32'hff);
      rd(PAIR_JOIN_ADDR);
      `CHK("join_rd", 2'h3, rd_v[1:0])
      in8 <= 8'h80;
      tick(3);
      `CHK("w16_ser", 1'b1, w16)
      `CHK("hs_ign", 8'h0, d.high_side_switch)
      wr(PAIR_JOIN_ADDR, 0);
      rd(PAIR_JOIN_ADDR);
      `CHK("join_ign", 2'h3, rd_v[1:0])
      for (int j = 1; j < 4; j++) begin
         in8 <= 8'h40;
         tick(2);
         wr(PAIR_JOIN_ADDR, j);
         in8 <= 8'h80;
         v = rnd();
         tick(2);
         wr(OUTPUT_STATE_ADDR, v);
         pp <= 1;
         tick(3);
         `CHK("hs_join", jmap(v, j[1:0]), d.high_side_switch)
         `CHK("ls_join", ~v & {j[1] ? 4'h0 : 4'hf, j[0] ? 4'h0 : 4'hf}, d.low_side)
         pp <= 0;
      end
      in8 <= 8'h40;
      tick(2);
      wr(PAIR_JOIN_ADDR, 0);
      // A join write without the low byte strobe must leave the join bits alone.
      wstrb <= 4'he;
      wr(PAIR_JOIN_ADDR, 3);
      wstrb <= 4'hf;
      rd(PAIR_JOIN_ADDR);
      `CHK("join_strb", 2'h0, rd_v[1:0])
      in8 <= 8'h01;
      // Open wires on channels 1 and 4: all switches off, then channel 4 on.
      for (int k = 0; k < 2; k++) begin
         wr(OUTPUT_STATE_ADDR, k ? 8'h08 : 8'h0);
         tick(4);
         `CHK("pull_up", (k ? 8'hf7 : 8'hff), d.pull_up)
         ow <= 8'h09;
         tick(12);
         `CHK("led_ol", 8'h09, d.fault_led)
         `CHK("fault_ol", 1'b1, fault_n_oe)
         rd(FAULT_FLAGS_ADDR);
         `CHK("flag_ol", 8'h09, rd_v[7:0])
         ow <= 0;
         tick(10);
         `CHK("led_hold", 8'h09, d.fault_led)
         tick(30);
         `CHK("fault_end", 1'b0, fault_n_oe)
         wr(FAULT_FLAGS_ADDR, 32'hff);
      end
      sd <= 8'h80;
      tick(3);
      `CHK("fault_sd", 1'b1, fault_n_oe)
      sd <= 0;
      flt <= 1;
      tick(2);
      csn <= 0;
      tick(1);
      csn <= 1;
      repeat (6) begin
         tick(1);
         `CHK("cs_glitch", 1'b1, csf)
      end
      csn <= 0;
      tick(8);
      `CHK("cs_low", 1'b0, csf)
      end_of_test();
   end
endmodule : tb_olc_top
